/* hdl/dst_fifo_if.sv */
// Carrier between the link core and its receive token memory.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface dst_fifo_if;
  logic wr_valid;
  logic wr_ready;
  logic [dst_pkg::TOK_W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [dst_pkg::TOK_W-1:0] rd_data;
  logic [dst_pkg::LVL_W-1:0] level;
  logic flush;

  modport store (
    input wr_valid, wr_data, rd_ready, flush,
    output wr_ready, rd_valid, rd_data, level
  );
  modport user (
    output wr_valid, wr_data, rd_ready, flush,
    input wr_ready, rd_valid, rd_data, level
  );
endinterface : dst_fifo_if

/* hdl/dst_link.sv */
// Data/strobe token link: bit coding, token parity, credit flow control,
// null filling and disconnect / parity recovery for one full-duplex port.
// Assumes the peer is an identical link and link pins are asynchronous.
//
// Functional notes
// RULE1: Each direction uses one data wire and one strobe wire.
// RULE2: Data wire carries bit; strobe toggles when bit repeats.
// RULE3: Receive timing recovered from data/strobe edges, no shared clock.
// RULE4: Transmit bit rate is programmable by a divider.
// RULE5: Each token starts with parity bit then data/control flag.
// RULE6: Data token has eight payload bits; control token two type bits.
// RULE7: Parity covers own flag plus previous token's payload bits.
// RULE8: Odd parity generated on transmit and checked on receive.
// RULE9: Any single-bit error, flag included, is detected.
// RULE10: Idle filler tokens sent whenever nothing else is pending.
// RULE11: Type codes 00 credit, 01 packet end, 10 message end, 11 prefix.
// RULE12: Receive buffer holds more than eight tokens.
// RULE13: Send a credit token whenever eight more tokens fit.
// RULE14: Eight flow-controlled tokens per received credit, then wait.
// RULE15: Credit tokens consumed here, never buffered; counted per token.
// RULE16: Packet is header, data bytes, then one terminator.
// RULE17: Packet end known only from terminator token.
// RULE18: After first token, 1.6 us silence is disconnect; halt, wait 12.8 us. Code arms the disconnect timer at the first received edge.
// RULE19: Parity error halts output so peer sees a disconnect.
// RULE20: Until first credit arrives, only fillers and credits are sent.
// RULE21: Parity failure or disconnect gives a host error pulse.
`timescale 1ns/10ps
module dst_link (
  input wire logic clk,                       // System clock, 20 MHz
  input wire logic rst,                       // Synchronous reset, active high
  input wire logic [7:0] rate_div,            // Clocks per transmitted bit minus one
  input wire logic rx_d,                      // Incoming data wire
  input wire logic rx_s,                      // Incoming strobe wire
  output logic tx_d,                          // Outgoing data wire
  output logic tx_s,                          // Outgoing strobe wire
  input wire logic tx_valid,                  // Host offers a token
  output logic tx_ready,                      // Transmit buffer has room
  input wire logic tx_ctrl,                   // Offered token is a terminator
  input wire logic [7:0] tx_byte,             // Data byte; bit 0 picks message end
  output logic rx_valid,                      // Received token available
  input wire logic rx_ready,                  // Host takes received token
  output logic rx_ctrl,                       // Received token is a terminator
  output logic [7:0] rx_byte,                 // Data byte or terminator type
  output logic link_up,                       // Link running
  output logic err_event                      // Any link fault: parity, disconnect, credit, escape or overflow
);

  typedef struct packed {
    dst_pkg::dst_state_t st;
    logic [dst_pkg::TMR_W-1:0] tmr;
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic px;
    logic seen;
    logic [dst_pkg::DISC_W-1:0] disc;
    logic [3:0] rpos;
    logic rflag;
    logic racc;
    logic rprev;
    logic resc;
    logic [7:0] rsh;
    logic [dst_pkg::CRED_W-1:0] outst;
    logic err;
    logic [7:0] tdiv;
    logic td;
    logic ts;
    logic [8:0] tsh;
    logic [3:0] tlen;
    logic tprev;
    logic nul2;
    logic fseen;
    logic [dst_pkg::CRED_W-1:0] tcred;
    logic [1:0] bcnt;
    logic [1:0][dst_pkg::TOK_W-1:0] buff;
  } dst_link_state_t;

  dst_link_state_t q;
  dst_link_state_t n;
  dst_fifo_if u_fif();

  logic push;
  logic [dst_pkg::TOK_W-1:0] tok;
  logic fault;
  logic bitv;
  logic edge_seen;
  logic [7:0] sh;
  logic [1:0] typ;
  logic tick_bit;
  logic tflag;
  logic [7:0] tpay;
  logic [3:0] tlen_new;
  logic [1:0] ttyp;
  logic pop_buf;
  logic take;
  logic [dst_pkg::CRED_W:0] need;

  // ==========================================================================
  // Receive token memory
  dst_tok_mem u_mem (
    .clk(clk),
    .rst(rst),
    .f(u_fif.store)
  );

  assign u_fif.wr_valid = push;
  assign u_fif.wr_data = tok;
  assign u_fif.rd_ready = rx_ready;
  assign u_fif.flush = q.st != dst_pkg::ST_RUN;
  assign rx_valid = u_fif.rd_valid;
  assign rx_ctrl = u_fif.rd_data[8];
  assign rx_byte = u_fif.rd_data[7:0];

  // ==========================================================================
  // Outputs
  assign tx_d = q.td;                                   // [RULE1]
  assign tx_s = q.ts;
  assign tx_ready = q.bcnt != dst_pkg::TXBUF_DEPTH;
  assign link_up = q.st == dst_pkg::ST_RUN;
  assign err_event = q.err;

  always_comb begin
    n = q;
    n.err = 1'b0;
    push = 1'b0;
    tok = '0;
    fault = 1'b0;
    sh = {q.sy2[1], q.rsh[7:1]};
    typ = {sh[6], sh[7]};
    tick_bit = 1'b0;
    tflag = 1'b0;
    tpay = '0;
    tlen_new = '0;
    ttyp = dst_pkg::CT_FLOW;
    pop_buf = 1'b0;
    take = 1'b0;
    need = 7'(q.outst) + 7'(u_fif.level) + 7'(dst_pkg::CREDIT_STEP);

    // ========================================================================
    // Pin synchronisers and edge finding
    n.sy1 = {rx_d, rx_s};
    n.sy2 = q.sy1;
    bitv = q.sy2[1];
    edge_seen = (q.sy2[1] ^ q.sy2[0]) != q.px;          // [RULE3]
    n.px = q.sy2[1] ^ q.sy2[0];

    case (q.st)
      dst_pkg::ST_WAIT: begin
        n.tmr = q.tmr + 1'b1;
        if (q.tmr == dst_pkg::SILENCE_LAST) begin       // [RULE18]
          n.tmr = '0;
          n.st = dst_pkg::ST_RUN;
        end
      end
      dst_pkg::ST_HALT: begin
        n = '0;
        n.sy1 = {rx_d, rx_s};
        n.sy2 = q.sy1;
        n.px = q.sy2[1] ^ q.sy2[0];
        n.td = q.td;                                    // [RULE19]
        n.ts = q.ts;
        n.st = dst_pkg::ST_WAIT;
      end
      dst_pkg::ST_RUN: begin
        // ====================================================================
        // Receive: token assembly and checking
        if (edge_seen) begin
          n.seen = 1'b1;
          n.disc = '0;
          case (q.rpos)
            4'h0: begin
              n.racc = bitv ^ q.rprev;                  // [RULE7]
              n.rpos = 4'h1;
            end
            4'h1: begin
              if (!(q.racc ^ bitv)) begin
                fault = 1'b1;                           // [RULE8] [RULE9]
              end
              n.rflag = bitv;                           // [RULE5]
              n.racc = 1'b0;
              n.rpos = 4'h2;
            end
            default: begin
              n.rsh = sh;
              n.racc = q.racc ^ bitv;
              n.rpos = q.rpos + 1'b1;
              if (q.rpos == (q.rflag ? dst_pkg::CTRL_LAST_POS : dst_pkg::DATA_LAST_POS)) begin
                n.rpos = '0;                            // [RULE6]
                n.rprev = q.racc ^ bitv;
                if (!q.rflag) begin
                  push = 1'b1;
                  tok = {1'b0, sh};
                  fault = q.resc;
                end else if (q.resc) begin
                  n.resc = 1'b0;
                  fault = typ != dst_pkg::CT_FLOW;      // [RULE11]
                end else begin
                  case (typ)
                    dst_pkg::CT_FLOW: begin
                      n.fseen = 1'b1;                   // [RULE15]
                      if (q.tcred > dst_pkg::CREDIT_MAX - dst_pkg::CREDIT_STEP) begin
                        fault = 1'b1;
                      end
                      n.tcred = q.tcred + dst_pkg::CREDIT_STEP;
                    end
                    dst_pkg::CT_PREFIX: begin
                      n.resc = 1'b1;
                    end
                    default: begin
                      push = 1'b1;                      // [RULE17]
                      tok = {1'b1, 6'h00, typ};
                    end
                  endcase
                end
                if (push) begin
                  if (q.outst == '0 || !u_fif.wr_ready) begin
                    fault = 1'b1;                       // [RULE12]
                    push = 1'b0;
                  end
                  n.outst = q.outst - 1'b1;
                end
              end
            end
          endcase
        end else if (q.seen) begin
          n.disc = q.disc + 1'b1;
          if (q.disc == dst_pkg::DISC_LAST) begin
            fault = 1'b1;                               // [RULE18]
          end
        end

        // ====================================================================
        // Transmit: token choice and bit coding
        if (q.tdiv == '0) begin
          n.tdiv = rate_div;                            // [RULE4]
          if (q.tlen != '0) begin
            tick_bit = q.tsh[0];
            n.tsh = {1'b0, q.tsh[8:1]};
            n.tlen = q.tlen - 1'b1;
          end else begin
            tflag = 1'b1;
            if (q.nul2) begin
              n.nul2 = 1'b0;                            // [RULE10]
              ttyp = dst_pkg::CT_FLOW;
            end else if (need <= dst_pkg::RXBUF_CAP) begin
              ttyp = dst_pkg::CT_FLOW;                  // [RULE13]
              n.outst = n.outst + dst_pkg::CREDIT_STEP;
            end else if (q.bcnt != '0 && n.tcred != '0 && q.fseen) begin
              pop_buf = 1'b1;                           // [RULE14] [RULE20]
              n.tcred = n.tcred - 1'b1;
              tflag = q.buff[0][8];
              ttyp = q.buff[0][0] ? dst_pkg::CT_MSG_END : dst_pkg::CT_PKT_END;
            end else begin
              ttyp = dst_pkg::CT_PREFIX;                // [RULE10] [RULE11]
              n.nul2 = 1'b1;
            end
            tpay = tflag ? {6'h00, ttyp[0], ttyp[1]} : q.buff[0][7:0];
            tlen_new = tflag ? dst_pkg::CTRL_TAIL_LEN : dst_pkg::DATA_TAIL_LEN;
            tick_bit = ~(tflag ^ q.tprev);              // [RULE7] [RULE8]
            n.tprev = ^tpay;
            n.tsh = {tpay, tflag};                      // [RULE5] [RULE6]
            n.tlen = tlen_new;
          end
          if (tick_bit != q.td) begin
            n.td = tick_bit;                            // [RULE2]
          end else begin
            n.ts = ~q.ts;                               // [RULE2]
          end
        end else begin
          n.tdiv = q.tdiv - 1'b1;
        end

        if (fault) begin
          n.st = dst_pkg::ST_HALT;                      // [RULE19]
          n.err = 1'b1;                                 // [RULE21]
        end
      end
      default: begin
        n.st = dst_pkg::ST_HALT;
      end
    endcase

    // ========================================================================
    // Two-entry transmit buffer; host framing passes through unchanged
    // Offers are taken in every state, but entries still waiting in the buffer are dropped when the link halts
    take = tx_valid && (q.bcnt != dst_pkg::TXBUF_DEPTH);  // [RULE16]
    if (pop_buf) begin
      n.buff[0] = q.buff[1];
      n.bcnt = q.bcnt - 1'b1;
    end
    if (take) begin
      n.buff[n.bcnt[0]] = {tx_ctrl, tx_byte};
      n.bcnt = n.bcnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule : dst_link

/* hdl/dst_pkg.sv */
// Constants, codes and types shared by the token link and its receive memory.
// Assumes a 20 MHz system clock; all times are turned into cycles here.
package dst_pkg;

  // ==========================================================================
  // Clock and times
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned DISC_TIME_NS = 1600;
  localparam int unsigned SILENCE_TIME_NS = 12800;
  // Longest time: round down
  localparam int unsigned DISC_CYC = DISC_TIME_NS / CLK_PERIOD_NS;
  // Least time: round up
  localparam int unsigned SILENCE_CYC = (SILENCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W = 9;
  localparam int unsigned DISC_W = 6;
  localparam logic [TMR_W-1:0] SILENCE_LAST = TMR_W'(SILENCE_CYC - 1);
  localparam logic [DISC_W-1:0] DISC_LAST = DISC_W'(DISC_CYC - 1);

  // ==========================================================================
  // Tokens and credit
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned TOK_W = DATA_BITS + 1;
  localparam int unsigned CRED_W = 6;
  localparam logic [CRED_W-1:0] CREDIT_STEP = 6'h08;
  localparam logic [CRED_W-1:0] CREDIT_MAX = 6'h3f;
  localparam logic [3:0] CTRL_LAST_POS = 4'h3;
  localparam logic [3:0] DATA_LAST_POS = 4'h9;
  localparam logic [3:0] CTRL_TAIL_LEN = 4'h3;
  localparam logic [3:0] DATA_TAIL_LEN = 4'h9;
  localparam logic [1:0] CT_FLOW = 2'h0;
  localparam logic [1:0] CT_PKT_END = 2'h1;
  localparam logic [1:0] CT_MSG_END = 2'h2;
  localparam logic [1:0] CT_PREFIX = 2'h3;

  // ==========================================================================
  // Receive memory and transmit buffer
  localparam int unsigned RXBUF_DEPTH = 16;
  localparam int unsigned RXBUF_AW = 4;
  localparam int unsigned LVL_W = 5;
  localparam logic [CRED_W:0] RXBUF_CAP = 7'h11;
  localparam logic [1:0] TXBUF_DEPTH = 2'h2;

  // ==========================================================================
  // Link states
  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_RUN = 2'h1,
    ST_HALT = 2'h3
  } dst_state_t;

endpackage : dst_pkg

/* hdl/dst_tok_mem.sv */
// Receive token memory with a registered read word (first word falls through).
// Assumes flush is held by the owner while the link is down.
`timescale 1ns/10ps
module dst_tok_mem (
  input wire logic clk,         // System clock
  input wire logic rst,         // Synchronous reset, active high
  dst_fifo_if.store f           // Write and read sides
);

  typedef struct packed {
    logic [dst_pkg::RXBUF_DEPTH-1:0][dst_pkg::TOK_W-1:0] mem;
    logic [dst_pkg::RXBUF_AW-1:0] wp;
    logic [dst_pkg::RXBUF_AW-1:0] rp;
    logic [dst_pkg::LVL_W-1:0] cnt;
    logic ov;
    logic [dst_pkg::TOK_W-1:0] od;
  } dst_mem_state_t;

  dst_mem_state_t q;
  dst_mem_state_t n;
  logic push;
  logic pop;
  logic load;

  assign f.wr_ready = q.cnt != dst_pkg::LVL_W'(dst_pkg::RXBUF_DEPTH);
  assign f.rd_valid = q.ov;
  assign f.rd_data = q.od;
  assign f.level = q.cnt + dst_pkg::LVL_W'(q.ov);

  always_comb begin
    n = q;
    push = f.wr_valid && f.wr_ready;
    pop = f.rd_ready && q.ov;
    load = (!q.ov || pop) && (q.cnt != '0);
    if (push) begin
      n.mem[q.wp] = f.wr_data;
      n.wp = q.wp + 1'b1;
    end
    if (load) begin
      n.od = q.mem[q.rp];
      n.rp = q.rp + 1'b1;
      n.ov = 1'b1;
    end else if (pop) begin
      n.ov = 1'b0;
    end
    n.cnt = q.cnt + dst_pkg::LVL_W'(push) - dst_pkg::LVL_W'(load);
    if (f.flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
      n.ov = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule : dst_tok_mem

/* test/dst_link_asserts.sv */
// Port assertions for the token link.
// Assumes one clock domain; bound into every link instance below.
`timescale 1ns/10ps
module dst_link_asserts (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic rx_d, // Data in
  input wire logic rx_s, // Strobe in
  input wire logic tx_d, // Data out
  input wire logic tx_s, // Strobe out
  input wire logic rx_valid, // Token held
  input wire logic rx_ready, // Token taken
  input wire logic rx_ctrl, // Terminator flag
  input wire logic [7:0] rx_byte, // Token value
  input wire logic link_up, // Running
  input wire logic err_event // Error pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [8:0] low_q;
  logic [5:0] quiet_q;
  logic seen_q;
  logic ex_q;
  // ==========================================================================
  // Down time and input silence counters
  always_ff @(posedge clk) begin
    ex_q <= rx_d ^ rx_s;
    low_q <= (rst || link_up) ? 9'h000 : low_q + {8'h00, low_q != 9'h1ff};
    if (rst || !link_up) begin
      seen_q <= 1'b0;
      quiet_q <= 6'h00;
    end else if ((rx_d ^ rx_s) != ex_q) begin
      seen_q <= 1'b1;
      quiet_q <= 6'h00;
    end else begin
      quiet_q <= quiet_q + {5'h00, quiet_q != 6'h3f};
    end
  end
  // ==========================================================================
  // Properties
  a_one_wire_step: assert property (!($changed(tx_d) && $changed(tx_s)))
    else $error("both link wires changed");
  a_halt_still: assert property (!link_up |=> $stable(tx_d) && $stable(tx_s))
    else $error("link wires moved while down");
  a_err_pulse: assert property (err_event |=> !err_event)
    else $error("error event longer than one cycle");
  a_err_halts: assert property (err_event |=> !link_up)
    else $error("link stayed up after error");
  a_down_flush: assert property (!link_up && $past(!link_up) |-> !rx_valid)
    else $error("token offered while link down");
  a_rx_hold: assert property (rx_valid && !rx_ready && link_up && !err_event |=>
    err_event || (rx_valid && $stable(rx_byte) && $stable(rx_ctrl)))
    else $error("held token changed or lost");
  a_term_code: assert property (rx_valid && rx_ctrl |-> rx_byte == 8'h01 || rx_byte == 8'h02)
    else $error("bad control token delivered");
  a_restart_gap: assert property ($rose(link_up) |-> low_q >= 9'h0fa)
    else $error("restart before silence time");
  a_disc_found: assert property (link_up && seen_q && quiet_q == 6'h28 |-> ##[0:2] !link_up)
    else $error("silent input not declared disconnect");
endmodule : dst_link_asserts

bind dst_link dst_link_asserts i_dst_link_asserts (.clk(clk), .rst(rst), .rx_d(rx_d),
  .rx_s(rx_s), .tx_d(tx_d), .tx_s(tx_s), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_ctrl(rx_ctrl), .rx_byte(rx_byte), .link_up(link_up), .err_event(err_event));

/* test/dst_link_bench.sv */
// Self-checking bench for the token link against the peer model.
// Assumes the checker is bound to the link by its own file.
`timescale 1ns/10ps
module dst_link_bench;
  logic clk = 1'b0, rst = 1'b1, tx_valid = 1'b0, tx_ctrl = 1'b0, rx_ready = 1'b0;
  logic rx_d, rx_s, tx_d, tx_s, tx_ready, rx_valid, rx_ctrl, link_up, err_event;
  logic [7:0] rate_div = 8'h07, tx_byte = 8'h00, rx_byte;
  logic [31:0] lfsr = 32'h0000_a9d7;
  int bad_count = 0, n_checks = 0;
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin bad_count++; \
  $display("[ERR] %0t got %0h want %0h", $time, (g), (w)); end end
  dst_link i_dst_link (
    .clk(clk), .rst(rst), .rate_div(rate_div), .rx_d(rx_d), .rx_s(rx_s), .tx_d(tx_d),
    .tx_s(tx_s), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ctrl(tx_ctrl),
    .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_ctrl(rx_ctrl),
    .rx_byte(rx_byte), .link_up(link_up), .err_event(err_event)
  );
  dst_peer i_dst_peer (.clk(clk), .tx_d(tx_d), .tx_s(tx_s), .rx_d(rx_d), .rx_s(rx_s));
  initial begin
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [8:0] exp_tok(input logic [8:0] t);
    return t[8] ? (t[0] ? 9'h102 : 9'h101) : t;
  endfunction : exp_tok
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic push(input logic [8:0] t);
    logic r;
    tx_valid <= 1'b1;
    tx_ctrl <= t[8];
    tx_byte <= t[7:0];
    r = 1'b0;
    for (int k = 0; k < 6000 && r !== 1'b1; k++) begin
      #1;
      r = tx_ready;
      @(posedge clk);
    end
    `CHK(r, 1'b1)
    if (r !== 1'b1) finish_test();
  endtask : push
  task automatic wait_up(input logic v);
    for (int k = 0; k < 2000 && link_up !== v; k++) @(posedge clk);
    `CHK(link_up, v)
    if (link_up !== v) finish_test();
  endtask : wait_up
  task automatic wait_got(input int c);
    for (int k = 0; k < 6000 && i_dst_peer.got.size() < c; k++) @(posedge clk);
    `CHK(i_dst_peer.got.size() >= c, 1'b1)
    if (i_dst_peer.got.size() < c) finish_test();
  endtask : wait_got
  initial begin
    logic [8:0] t;
    logic [8:0] u;
    logic [8:0] exq[$];
    logic [8:0] rxq[$];
    rate_div <= 8'h07 + {6'h00, lfsr[1:0]};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(tx_ready, 1'b1)
    wait_up(1'b1);
    i_dst_peer.go = 1'b1;
    repeat (600) @(posedge clk);
    `CHK(i_dst_peer.cred_n, int'(dst_pkg::RXBUF_CAP) / 8)
    `CHK(i_dst_peer.fill_n > 0, 1'b1)
    `CHK(i_dst_peer.perr_n, 0)
    $display("test bring-up done");
    for (int i = 0; i < 10; i++) begin
      lfsr = nxt(lfsr);
      t = (i == 5) ? 9'h100 : (i == 9) ? 9'h101 : {1'b0, lfsr[7:0]};
      exq.push_back(exp_tok(t));
      push(t);
      if (i == 1) begin
        tx_valid <= 1'b0;
        repeat (300) @(posedge clk);
        #1;
        `CHK(tx_ready, 1'b0)
        `CHK(i_dst_peer.got.size(), 0)
        i_dst_peer.txq.push_back(9'h100);
        @(posedge clk);
      end
    end
    tx_valid <= 1'b0;
    wait_got(8);
    repeat (400) @(posedge clk);
    `CHK(i_dst_peer.got.size(), 8)
    i_dst_peer.txq.push_back(9'h100);
    wait_got(10);
    while (exq.size() != 0) begin
      t = i_dst_peer.got.pop_front();
      u = exq.pop_front();
      `CHK(t, u)
    end
    $display("test transmit done");
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      t = (i == 7) ? 9'h101 : (i == 15) ? 9'h102 : {1'b0, lfsr[7:0]};
      i_dst_peer.txq.push_back(t);
      rxq.push_back(t);
      if (i == 3) i_dst_peer.txq.push_back(9'h100);
    end
    for (int k = 0; k < 8000 && i_dst_peer.txq.size() != 0; k++) @(posedge clk);
    `CHK(i_dst_peer.txq.size(), 0)
    if (i_dst_peer.txq.size() != 0) finish_test();
    repeat (300) @(posedge clk);
    `CHK(link_up, 1'b1)
    `CHK(i_dst_peer.cred_n, 2)
    for (int k = 0; k < 3000 && rxq.size() != 0; k++) begin
      @(posedge clk);
      lfsr = nxt(lfsr);
      rx_ready <= lfsr[0] | lfsr[1];
      #1;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
        u = rxq.pop_front();
        `CHK({rx_ctrl, rx_byte}, u)
      end
    end
    @(posedge clk);
    rx_ready <= 1'b0;
    `CHK(rxq.size(), 0)
    if (rxq.size() != 0) finish_test();
    repeat (600) @(posedge clk);
    `CHK(rx_valid, 1'b0)
    `CHK(i_dst_peer.cred_n, 4)
    $display("test receive done");
    for (int m = 0; m < 2; m++) begin
      if (m == 0) i_dst_peer.bad = 1'b1;
      else i_dst_peer.go = 1'b0;
      for (int k = 0; k < 600 && err_event !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      `CHK(err_event, 1'b1)
      if (err_event !== 1'b1) finish_test();
      i_dst_peer.go = 1'b0;
      @(posedge clk);
      #1;
      `CHK(link_up, 1'b0)
      repeat (200) @(posedge clk);
      i_dst_peer.clear();
      wait_up(1'b1);
      i_dst_peer.go = 1'b1;
      repeat (600) @(posedge clk);
      `CHK(i_dst_peer.cred_n, int'(dst_pkg::RXBUF_CAP) / 8)
      `CHK(i_dst_peer.perr_n, 0)
      $display("test error %0d done", m);
    end
    finish_test();
  end
endmodule : dst_link_bench

/* test/dst_peer.sv */
// Peer link model: sends tokens on its own 400 ns bit timing, decodes the block's output.
// Assumes the bench fills txq and calls clear while both directions are silent.
`timescale 1ns/10ps
module dst_peer (
  input wire logic clk, // Sampling clock
  input wire logic tx_d, // Data from the block
  input wire logic tx_s, // Strobe from the block
  output logic rx_d, // Data to the block
  output logic rx_s // Strobe to the block
);
  logic go = 1'b0, bad = 1'b0, sp = 1'b0, rp = 1'b0, pre = 1'b0, px = 1'b0;
  logic [9:0] b = 10'h000;
  logic [8:0] txq[$];
  logic [8:0] got[$];
  int n = 0, cred = 0, cred_n = 0, fill_n = 0, perr_n = 0;
  task automatic put_bit(input logic v);
    #400;
    rx_s = (v == rx_d) ? ~rx_s : rx_s;
    rx_d = v;
  endtask : put_bit
  task automatic put_tok(input logic [8:0] t);
    put_bit(~(t[8] ^ sp) ^ bad);
    bad = 1'b0;
    put_bit(t[8]);
    if (t[8]) begin
      put_bit(t[1]);
      put_bit(t[0]);
      sp = t[1] ^ t[0];
    end else begin
      for (int i = 0; i < 8; i++) put_bit(t[i]);
      sp = ^t[7:0];
    end
  endtask : put_tok
  task automatic clear();
    sp = 1'b0;
    rp = 1'b0;
    pre = 1'b0;
    n = 0;
    cred = 0;
    cred_n = 0;
    fill_n = 0;
    perr_n = 0;
    px = tx_d ^ tx_s;
    got.delete();
  endtask : clear
  // ==========================================================================
  // Sender: flow tokens only on credit, fillers otherwise
  initial begin
    rx_d = 1'b0;
    rx_s = 1'b0;
    #7;
    forever begin
      if (!go) #50;
      else if (txq.size() != 0 && (cred > 0 || txq[0] == 9'h100)) begin
        if (txq[0] != 9'h100) cred--;
        put_tok(txq.pop_front());
      end else begin
        put_tok(9'h103);
        put_tok(9'h100);
      end
    end
  end
  // ==========================================================================
  // Receiver of the block's output
  always @(posedge clk) begin
    if ((tx_d ^ tx_s) != px) begin
      px = tx_d ^ tx_s;
      b[n] = tx_d;
      n++;
      if (n >= 4 && n == (b[1] ? 4 : 10)) begin
        n = 0;
        if ((b[0] ^ b[1] ^ rp) !== 1'b1) perr_n++;
        rp = b[1] ? (b[2] ^ b[3]) : ^b[9:2];
        if (!b[1]) got.push_back({1'b0, b[9:2]});
        else if ({b[2], b[3]} == 2'b11) pre = 1'b1;
        else if (pre) begin
          fill_n++;
          pre = 1'b0;
        end else if ({b[2], b[3]} == 2'b00) begin
          cred_n++;
          cred += 8;
        end else got.push_back({7'h40, b[2], b[3]});
      end
    end
  end
endmodule : dst_peer
